// File: common/nvm_pkg.sv
/*
 Constants, field positions and encodings of the nonvolatile memory access block.
 Assumes a 250 MHz system clock and a 16-bit Avalon-MM byte address.
*/
package nvm_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int NVM_AW = 16;
	// Latch bytes: offsets are indices, byte address is index * 4
	localparam logic [15:0] NVM_PORT_DRIVE_LOW_IDX = 16'h0000;
	localparam logic [15:0] NVM_PORT_DRIVE_HIGH_IDX = 16'h0001;
	localparam logic [15:0] NVM_RESET_DEBUG_IDX = 16'h0002;
	localparam logic [15:0] NVM_BOOT_CLOCK_ECC_IDX = 16'h0003;
	localparam logic [15:0] NVM_ECC_STATUS = 16'h0010;
	localparam logic [15:0] NVM_ECC_MASK = 16'h0014;
	localparam logic [15:0] NVM_ECC_ADDR = 16'h0018;
	localparam logic [15:0] NVM_EE_CMD = 16'h001C;
	localparam logic [15:0] NVM_EE_ROW = 16'h0020;
	localparam logic [15:0] NVM_EE_BUF = 16'h0030;
	localparam logic [15:0] NVM_EE_WIN = 16'h1000;
	localparam logic [7:0] NVM_EE_CMD_PROGRAM = 8'h01;
	localparam logic [7:0] NVM_EE_CMD_ERASE = 8'h02;

	// ----------------------------------------------------------------
	// Latch fields and factory values
	// ----------------------------------------------------------------
	localparam logic [7:0] NVM_LATCH0_RESET = 8'h00;
	localparam logic [7:0] NVM_LATCH1_RESET = 8'h00;
	localparam logic [7:0] NVM_LATCH2_RESET = 8'h40;
	localparam logic [7:0] NVM_LATCH3_RESET = 8'h0A;
	localparam int NVM_EXT_RESET_SEL_BIT = 7;
	localparam int NVM_DEBUG_ALLOW_BIT = 6;
	localparam int NVM_BOOT_SPEED_BIT = 0;
	localparam int NVM_DBG_PORT_LSB = 1;
	localparam int NVM_CHECK_EN_BIT = 3;
	localparam int NVM_PHASE_LSB = 4;
	localparam int NVM_NUM_PORTS = 9;

	// ----------------------------------------------------------------
	// Memory geometry and timing
	// ----------------------------------------------------------------
	localparam int NVM_EE_ROWS = 128;
	localparam int NVM_EE_ROW_BYTES = 16;
	localparam int NVM_EE_BYTES = 2048;
	localparam int NVM_FL_ROWS = 1024;
	localparam int NVM_FL_ROW_BYTES = 256;
	localparam int NVM_FL_CHECK_BYTES = 32;
	localparam int NVM_GROUP_BYTES = 8;
	localparam int NVM_CLK_MHZ = 250;
	localparam int NVM_EE_WRITE_US = 20000;
	localparam int NVM_EE_WRITE_CYC = NVM_EE_WRITE_US * NVM_CLK_MHZ;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		NVM_PROT_NONE = 2'b00,
		NVM_PROT_FACTORY = 2'b01,
		NVM_PROT_FIELD = 2'b10,
		NVM_PROT_FULL = 2'b11
	} nvm_prot_t;
	typedef enum logic [1:0] {
		NVM_PG_READ = 2'b00,
		NVM_PG_WRITE = 2'b01,
		NVM_PG_SET_LEVEL = 2'b10,
		NVM_PG_FULL_ERASE = 2'b11
	} nvm_pg_op_t;
	localparam logic [1:0] NVM_DRIVE_ANALOG_HIZ = 2'b00;
	localparam logic [1:0] NVM_DRIVE_DIGITAL_HIZ = 2'b01;
	localparam logic [1:0] NVM_DRIVE_PULL_UP = 2'b10;
	localparam logic [1:0] NVM_DRIVE_PULL_DOWN = 2'b11;
	localparam logic [1:0] NVM_DBG_PORT_JTAG5 = 2'b00;
	localparam logic [1:0] NVM_DBG_PORT_JTAG4 = 2'b01;
	localparam logic [1:0] NVM_DBG_PORT_SWD = 2'b10;
	localparam logic [1:0] NVM_DBG_PORT_OFF = 2'b11;
endpackage

// File: logic/nvm_core.sv
/*
 Nonvolatile memory access logic: flash read path with single-correct double-detect
 checking, per-row flash protection, byte-readable row-written data memory, and the
 4-byte configuration latch array applied at reset.
 Assumes the flash macro returns a 9-byte word one cycle after fl_rd_en, and that all
 request ports are driven by logic on clk.
*/
`timescale 1ns/1ps
// Behaviour
// - Correct one-bit, detect two-bit errors in each 8-byte flash group.
// - A detected flash error can raise an interrupt to software.
// - Each flash read returns 8 data bytes plus 1 check byte.
// - Instruction fetches from the check-byte flash region are refused.
// - Flash reads outside the check-byte region pass the checker, corrected when checking is enabled.
// - Flash reads stall while flash program or erase is busy.
// - Flash blocks hold 256 data bytes plus 32 check bytes.
// - Each row has one of four levels; only full erase lowers it.
// - Levels gate external read/write and internal write as tabled.
// - Data memory is 2 KB, read directly byte by byte.
// - Data memory writes go by command; flash reads continue meanwhile.
// - Data memory is erased and written per row, 128 rows of 16 bytes.
// - Erased data memory bytes read as zero.
// - Data memory has no checking and no instruction fetch path.
// - Four latch bytes hold configuration, applied at reset.
// - Per-port two-bit field selects the port drive state at reset.
// - Reset-pin select bit chooses GPIO (0) or external reset input (1).
// - Debug access bit disables (0) or enables (1, default) debug access.
// - Boot clock bit selects 12 MHz (0) or 48 MHz (1) oscillator.
// - Check-enable bit makes check flash hold codes (1) or user data (0).
module nvm_core #(
	parameter int EE_WRITE_CYC = nvm_pkg::NVM_EE_WRITE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic por,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rd_req,
	input wire logic [17:0] rd_addr,
	input wire logic rd_fetch,
	input wire logic rd_check_region,
	output logic rd_ack,
	output logic [63:0] rd_data,
	output logic rd_fault,
	output logic rd_corrected,
	output logic rd_uncorrectable,
	output logic fl_rd_en,
	output logic [14:0] fl_rd_addr,
	output logic fl_rd_check_region,
	input wire logic [71:0] fl_rd_word,
	input wire logic fl_busy,
	input wire logic pg_req,
	input wire logic [1:0] pg_op,
	input wire logic pg_ext,
	input wire logic [9:0] pg_row,
	input wire logic [1:0] pg_level,
	output logic pg_done,
	output logic pg_allowed,
	output logic ecc_irq,
	output logic ee_busy,
	output logic [17:0] port_reset_drive_select,
	output logic ext_reset_pin_select,
	output logic debug_access_allow,
	output logic boot_clock_speed,
	output logic [1:0] debug_port_select,
	output logic check_bytes_enable,
	output logic [3:0] digital_clock_phase_delay
);
	// ----------------------------------------------------------------
	// Check code functions
	// ----------------------------------------------------------------
	// Codeword bit 0 is the overall parity, powers of two hold check bits
	function automatic logic [71:0] nvm_pack(input logic [63:0] d, input logic [7:0] c);
		logic [71:0] cw;
		int k;
		int j;
		cw = '0;
		k = 0;
		j = 0;
		cw[0] = c[7];
		for (int p = 1; p < 72; p++) begin
			if ((p & (p - 1)) == 0) begin
				cw[p] = c[j];
				j++;
			end else begin
				cw[p] = d[k];
				k++;
			end
		end
		return cw;
	endfunction

	function automatic logic [63:0] nvm_unpack(input logic [71:0] cw);
		logic [63:0] d;
		int k;
		d = '0;
		k = 0;
		for (int p = 1; p < 72; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = cw[p];
				k++;
			end
		end
		return d;
	endfunction

	function automatic logic [6:0] nvm_syndrome(input logic [71:0] cw);
		logic [6:0] s;
		s = '0;
		for (int p = 1; p < 72; p++) begin
			if (cw[p]) begin
				s = s ^ 7'(p);
			end
		end
		return s;
	endfunction

	// ----------------------------------------------------------------
	// Configuration latches
	// ----------------------------------------------------------------
	logic [7:0] latch [4];
	logic [7:0] applied [4];
	logic bus_ack;
	wire bus_req = (avs_read | avs_write) & ~bus_ack;
	wire wr_take = avs_write & bus_ack & ce;
	wire [15:0] latch_end = 16'(nvm_pkg::NVM_BOOT_CLOCK_ECC_IDX << 2);
	wire latch_hit = avs_address <= latch_end && avs_address[1:0] == 2'b00;
	wire [1:0] latch_sel = avs_address[3:2];

	always_ff @(posedge clk) begin
		if (por) begin
			latch[0] <= nvm_pkg::NVM_LATCH0_RESET;
			latch[1] <= nvm_pkg::NVM_LATCH1_RESET;
			latch[2] <= nvm_pkg::NVM_LATCH2_RESET;
			latch[3] <= nvm_pkg::NVM_LATCH3_RESET;
		end else if (wr_take && latch_hit && avs_byteenable[0]) begin
			latch[latch_sel] <= avs_writedata[7:0];
		end
	end

	// Latch contents take effect only at reset
	always_ff @(posedge clk) begin
		if (rst || por) begin
			for (int i = 0; i < 4; i++) begin
				applied[i] <= por ? 8'h00 : latch[i];
			end
			if (por) begin
				applied[2] <= nvm_pkg::NVM_LATCH2_RESET;
				applied[3] <= nvm_pkg::NVM_LATCH3_RESET;
			end
		end
	end

	assign port_reset_drive_select = {applied[2][1:0], applied[1], applied[0]};
	assign ext_reset_pin_select = applied[2][nvm_pkg::NVM_EXT_RESET_SEL_BIT];
	assign debug_access_allow = applied[2][nvm_pkg::NVM_DEBUG_ALLOW_BIT];
	assign boot_clock_speed = applied[3][nvm_pkg::NVM_BOOT_SPEED_BIT];
	assign debug_port_select = applied[3][nvm_pkg::NVM_DBG_PORT_LSB +: 2];
	assign check_bytes_enable = applied[3][nvm_pkg::NVM_CHECK_EN_BIT];
	assign digital_clock_phase_delay = applied[3][nvm_pkg::NVM_PHASE_LSB +: 4];

	// ----------------------------------------------------------------
	// Flash read path
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		NVM_RD_IDLE = 1'b0,
		NVM_RD_DATA = 1'b1
	} nvm_rd_state_t;
	nvm_rd_state_t rd_state;
	nvm_rd_state_t next_rd_state;
	logic [17:0] rd_addr_q;
	logic rd_region_q;
	wire fetch_refused = rd_fetch & rd_check_region;
	wire rd_start = rd_state == NVM_RD_IDLE && rd_req && !rd_ack && !fetch_refused;
	wire rd_launch = rd_start & ~fl_busy;

	// One flash word carries 8 data bytes and 1 check byte
	wire [71:0] cw = nvm_pack(fl_rd_word[63:0], fl_rd_word[71:64]);
	wire [6:0] syn = nvm_syndrome(cw);
	wire par_err = ^cw;
	wire do_check = check_bytes_enable & ~rd_region_q;
	wire sec = do_check & par_err;
	wire ded = do_check & ~par_err & (syn != 7'h00);
	wire [71:0] cw_fix = cw ^ (72'h1 << syn);
	wire [63:0] word_out = sec ? nvm_unpack(cw_fix) : fl_rd_word[63:0];

	assign fl_rd_en = rd_launch & ce;
	assign fl_rd_addr = rd_addr[17:3];
	assign fl_rd_check_region = rd_check_region;

	always_comb begin
		next_rd_state = rd_state;
		unique case (rd_state)
			NVM_RD_IDLE: begin
				if (rd_launch) begin
					next_rd_state = NVM_RD_DATA;
				end
			end
			NVM_RD_DATA: begin
				next_rd_state = NVM_RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_state <= NVM_RD_IDLE;
			rd_ack <= 1'b0;
			rd_fault <= 1'b0;
			rd_corrected <= 1'b0;
			rd_uncorrectable <= 1'b0;
			rd_data <= '0;
			rd_addr_q <= '0;
			rd_region_q <= 1'b0;
		end else if (ce) begin
			rd_state <= next_rd_state;
			rd_ack <= (rd_state == NVM_RD_DATA) |
				(rd_state == NVM_RD_IDLE && rd_req && !rd_ack && fetch_refused);
			rd_fault <= rd_state == NVM_RD_IDLE && rd_req && !rd_ack && fetch_refused;
			rd_corrected <= rd_state == NVM_RD_DATA && sec;
			rd_uncorrectable <= rd_state == NVM_RD_DATA && ded;
			if (rd_state == NVM_RD_DATA) begin
				rd_data <= word_out;
			end
			if (rd_launch) begin
				rd_addr_q <= rd_addr;
				rd_region_q <= rd_check_region;
			end
		end
	end

	// ----------------------------------------------------------------
	// Error status and interrupt
	// ----------------------------------------------------------------
	logic [1:0] ecc_status;
	logic [1:0] ecc_mask;
	logic [17:0] ecc_addr;
	wire [1:0] ecc_event = {rd_state == NVM_RD_DATA && ded, rd_state == NVM_RD_DATA && sec};
	wire ecc_clr = wr_take && avs_address == nvm_pkg::NVM_ECC_STATUS && avs_byteenable[0];
	wire mask_wr = wr_take && avs_address == nvm_pkg::NVM_ECC_MASK && avs_byteenable[0];

	always_ff @(posedge clk) begin
		if (rst) begin
			ecc_status <= 2'h0;
			ecc_mask <= 2'h0;
			ecc_addr <= '0;
		end else if (ce) begin
			// Set wins over a simultaneous write-one clear
			ecc_status <= (ecc_status & ~(ecc_clr ? avs_writedata[1:0] : 2'h0)) | ecc_event;
			if (mask_wr) begin
				ecc_mask <= avs_writedata[1:0];
			end
			if (|ecc_event) begin
				ecc_addr <= rd_addr_q;
			end
		end
	end

	assign ecc_irq = |(ecc_status & ecc_mask);

	// ----------------------------------------------------------------
	// Flash protection
	// ----------------------------------------------------------------
	logic [1:0] prot [nvm_pkg::NVM_FL_ROWS]; // One level per 256+32 byte block
	nvm_pkg::nvm_prot_t lvl;
	assign lvl = nvm_pkg::nvm_prot_t'(prot[pg_row]);
	wire ext_ok = debug_access_allow && debug_port_select != nvm_pkg::NVM_DBG_PORT_OFF;
	wire op_rd = pg_op == nvm_pkg::NVM_PG_READ;
	wire op_wr = pg_op == nvm_pkg::NVM_PG_WRITE;
	wire op_set = pg_op == nvm_pkg::NVM_PG_SET_LEVEL;
	wire op_erase = pg_op == nvm_pkg::NVM_PG_FULL_ERASE;
	// External read only when unprotected; external write up to factory upgrade
	wire ext_rd_ok = lvl == nvm_pkg::NVM_PROT_NONE;
	wire ext_wr_ok = lvl == nvm_pkg::NVM_PROT_NONE || lvl == nvm_pkg::NVM_PROT_FACTORY;
	wire int_wr_ok = lvl != nvm_pkg::NVM_PROT_FULL;
	wire set_ok = lvl == nvm_pkg::NVM_PROT_NONE;
	wire pg_ok = op_erase ? (!pg_ext || ext_ok) :
		op_set ? set_ok && (!pg_ext || ext_ok) :
		pg_ext ? ext_ok && (op_rd ? ext_rd_ok : ext_wr_ok) :
		(op_rd || int_wr_ok);
	wire pg_take = pg_req & ~pg_done;

	always_ff @(posedge clk) begin
		if (por) begin
			for (int r = 0; r < nvm_pkg::NVM_FL_ROWS; r++) begin
				prot[r] <= nvm_pkg::NVM_PROT_NONE;
			end
		end else if (ce && pg_take && pg_ok) begin
			if (op_erase) begin
				for (int r = 0; r < nvm_pkg::NVM_FL_ROWS; r++) begin
					prot[r] <= nvm_pkg::NVM_PROT_NONE;
				end
			end else if (op_set) begin
				prot[pg_row] <= pg_level;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pg_done <= 1'b0;
			pg_allowed <= 1'b0;
		end else if (ce) begin
			pg_done <= pg_take;
			pg_allowed <= pg_take & pg_ok;
		end
	end

	// ----------------------------------------------------------------
	// Data memory, 128 rows of 16 bytes
	// ----------------------------------------------------------------
	logic [7:0] ee_mem [nvm_pkg::NVM_EE_BYTES];
	logic [nvm_pkg::NVM_EE_ROWS-1:0] ee_row_valid;
	logic [31:0] ee_buf [4];
	logic [6:0] ee_row;
	logic ee_prog;
	logic [31:0] ee_cnt;
	wire ee_win_hit = avs_address >= nvm_pkg::NVM_EE_WIN &&
		avs_address < 16'(nvm_pkg::NVM_EE_WIN + 16'(nvm_pkg::NVM_EE_BYTES * 4));
	wire [10:0] ee_byte = avs_address[12:2] - 11'(nvm_pkg::NVM_EE_WIN >> 2);
	wire ee_buf_hit = avs_address[15:4] == nvm_pkg::NVM_EE_BUF[15:4];
	wire cmd_wr = wr_take && avs_address == nvm_pkg::NVM_EE_CMD && avs_byteenable[0];
	wire ee_go = cmd_wr && !ee_busy && (avs_writedata[7:0] == nvm_pkg::NVM_EE_CMD_PROGRAM ||
		avs_writedata[7:0] == nvm_pkg::NVM_EE_CMD_ERASE);
	wire ee_end = ee_busy && ee_cnt == 32'(EE_WRITE_CYC - 1);

	always_ff @(posedge clk) begin
		if (rst) begin
			ee_busy <= 1'b0;
			ee_prog <= 1'b0;
			ee_cnt <= '0;
			ee_row <= '0;
		end else if (ce) begin
			if (wr_take && avs_address == nvm_pkg::NVM_EE_ROW && !ee_busy) begin
				ee_row <= avs_writedata[6:0];
			end
			if (ee_go) begin
				ee_busy <= 1'b1;
				ee_prog <= avs_writedata[7:0] == nvm_pkg::NVM_EE_CMD_PROGRAM;
				ee_cnt <= '0;
			end else if (ee_end) begin
				ee_busy <= 1'b0;
			end else if (ee_busy) begin
				ee_cnt <= ee_cnt + 32'h1;
			end
		end
	end

	// Whole-row commit at the end of the write time
	always_ff @(posedge clk) begin
		if (por) begin
			ee_row_valid <= '0;
		end else if (ce && ee_end) begin
			ee_row_valid[ee_row] <= ee_prog;
		end
	end

	always_ff @(posedge clk) begin
		if (ce && wr_take && ee_buf_hit) begin
			for (int b = 0; b < 4; b++) begin
				if (avs_byteenable[b]) begin
					ee_buf[avs_address[3:2]][8*b +: 8] <= avs_writedata[8*b +: 8];
				end
			end
		end
		if (ce && ee_end && ee_prog) begin
			for (int i = 0; i < nvm_pkg::NVM_EE_ROW_BYTES; i++) begin
				ee_mem[{ee_row, 4'(i)}] <= ee_buf[i / 4][8 * (i % 4) +: 8];
			end
		end
	end

	// Direct byte read, no checking, bus-only so no fetch path
	wire [7:0] ee_rd_byte = ee_row_valid[ee_byte[10:4]] ? ee_mem[ee_byte] : 8'h00;

	// ----------------------------------------------------------------
	// Avalon-MM slave, one wait state on every access
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		if (latch_hit) begin
			rd_mux = {24'h0, latch[latch_sel]};
		end else if (avs_address == nvm_pkg::NVM_ECC_STATUS) begin
			rd_mux = {30'h0, ecc_status};
		end else if (avs_address == nvm_pkg::NVM_ECC_MASK) begin
			rd_mux = {30'h0, ecc_mask};
		end else if (avs_address == nvm_pkg::NVM_ECC_ADDR) begin
			rd_mux = {14'h0, ecc_addr};
		end else if (avs_address == nvm_pkg::NVM_EE_CMD) begin
			rd_mux = {31'h0, ee_busy};
		end else if (avs_address == nvm_pkg::NVM_EE_ROW) begin
			rd_mux = {25'h0, ee_row};
		end else if (ee_buf_hit) begin
			rd_mux = ee_buf[avs_address[3:2]];
		end else if (ee_win_hit) begin
			rd_mux = {24'h0, ee_rd_byte};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_ack <= 1'b0;
			avs_readdata <= '0;
		end else if (ce) begin
			bus_ack <= bus_req;
			if (bus_req && avs_read) begin
				avs_readdata <= rd_mux;
			end
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
endmodule

// File: dv/nvm_core_assertions.sv
/*
 Port-level checks of nvm_core, bound to every instance.
 Assumes one clock, synchronous active-high rst, ce held high.
*/
`timescale 1ns/1ps
module nvm_core_assertions #(
	parameter int EE_WRITE_CYC = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic rd_fetch,
	input wire logic rd_check_region,
	input wire logic rd_ack,
	input wire logic rd_fault,
	input wire logic rd_corrected,
	input wire logic rd_uncorrectable,
	input wire logic fl_rd_en,
	input wire logic fl_busy,
	input wire logic pg_req,
	input wire logic pg_ext,
	input wire logic pg_done,
	input wire logic pg_allowed,
	input wire logic ecc_irq,
	input wire logic ee_busy,
	input wire logic debug_access_allow,
	input wire logic check_bytes_enable
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	logic [31:0] busy_cnt;
	always_ff @(posedge clk) begin
		if (rst || !ee_busy) begin
			busy_cnt <= 32'h0;
		end else begin
			busy_cnt <= busy_cnt + 32'h1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	sequence s_clean_ack;
		##2 (rd_ack && !rd_fault);
	endsequence
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_bus_one_wait: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
		else $error("bus wait state count wrong");
	chk_read_answer: assert property (fl_rd_en |-> s_clean_ack)
		else $error("flash read answer late or faulted");
	chk_busy_stall: assert property (fl_busy |-> !fl_rd_en)
		else $error("flash read launched while busy");
	chk_fetch_refused: assert property (rd_fetch && rd_check_region |-> !fl_rd_en)
		else $error("fetch from check region reached flash");
	chk_fault_cause: assert property (rd_fault |-> rd_ack && $past(rd_fetch && rd_check_region))
		else $error("fault without refused fetch");
	chk_flag_cause: assert property (rd_corrected || rd_uncorrectable |->
		rd_ack && check_bytes_enable && !(rd_corrected && rd_uncorrectable))
		else $error("error flags inconsistent");
	chk_prot_answer: assert property (pg_req && !pg_done |=> pg_done)
		else $error("protection request not answered");
	chk_debug_block: assert property (pg_req && !pg_done && pg_ext && !debug_access_allow
		|=> !pg_allowed)
		else $error("external access granted with debug off");
	chk_irq_reset: assert property ($fell(rst) |-> !ecc_irq)
		else $error("interrupt high after reset");
	chk_latch_hold: assert property (!rst |=> $stable({debug_access_allow, check_bytes_enable}))
		else $error("configuration changed outside reset");
	chk_ee_busy_len: assert property ($fell(ee_busy) |->
		busy_cnt >= EE_WRITE_CYC && busy_cnt <= EE_WRITE_CYC + 1)
		else $error("data memory write length wrong");
endmodule

bind nvm_core nvm_core_assertions #(.EE_WRITE_CYC(EE_WRITE_CYC)) chk_i (.clk(clk), .rst(rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.rd_fetch(rd_fetch), .rd_check_region(rd_check_region), .rd_ack(rd_ack),
	.rd_fault(rd_fault), .rd_corrected(rd_corrected), .rd_uncorrectable(rd_uncorrectable),
	.fl_rd_en(fl_rd_en), .fl_busy(fl_busy), .pg_req(pg_req), .pg_ext(pg_ext),
	.pg_done(pg_done), .pg_allowed(pg_allowed), .ecc_irq(ecc_irq), .ee_busy(ee_busy),
	.debug_access_allow(debug_access_allow), .check_bytes_enable(check_bytes_enable));

// File: dv/nvm_flash_model.sv
/*
 Flash macro model: 9-byte word one cycle after a read strobe.
 Assumes the bench sets flip to inject bit errors.
*/
`timescale 1ns/1ps
module nvm_flash_model (
	input wire logic clk,
	input wire logic fl_rd_en,
	input wire logic [14:0] fl_rd_addr,
	input wire logic [71:0] flip,
	output logic [71:0] fl_rd_word
);
	function automatic logic [7:0] code(input logic [63:0] d);
		logic [7:0] c;
		int k;
		c = 8'h00;
		k = 0;
		for (int p = 3; p < 72; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (d[k]) c[6:0] ^= p[6:0];
				k++;
			end
		end
		c[7] = ^{c[6:0], d};
		return c;
	endfunction
	logic [63:0] data;
	assign data = {4{1'b0, fl_rd_addr}};
	initial fl_rd_word = 72'h0;
	always @(posedge clk) begin
		if (fl_rd_en) begin
			fl_rd_word <= {code(data), data} ^ flip;
		end else begin
			fl_rd_word <= ~fl_rd_word;
		end
	end
endmodule

// File: dv/test_nv_memory_ecc_protection_config.sv
/*
 Self-checking bench of nvm_core over Avalon, flash and protection ports.
 Assumes nvm_flash_model as the flash macro and a short data memory write.
*/
`timescale 1ns/1ps
module test_nv_memory_ecc_protection_config;
	logic clk = 1'b0, rst = 1'b1, por = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [15:0] avs_address = 16'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic rd_req = 1'b0, rd_fetch = 1'b0, rd_check_region = 1'b0, fl_busy = 1'b0;
	logic [17:0] rd_addr = 18'h0;
	logic pg_req = 1'b0, pg_ext = 1'b0;
	logic [1:0] pg_op = 2'h0, pg_level = 2'h0, debug_port_select;
	logic [71:0] flip = 72'h0, fl_rd_word;
	logic [63:0] rd_data, d;
	logic [14:0] fl_rd_addr;
	logic [17:0] port_reset_drive_select;
	logic [3:0] digital_clock_phase_delay;
	logic [2:0] fl;
	logic avs_waitrequest, rd_ack, rd_fault, rd_corrected, rd_uncorrectable, fl_rd_en;
	logic pg_done, pg_allowed, ecc_irq, ee_busy, ext_reset_pin_select, debug_access_allow;
	logic boot_clock_speed, check_bytes_enable;
	logic [27:0] cfg;
	logic [5:0] pt[16] = '{6'h09, 6'h23, 6'h08, 6'h19, 6'h24, 6'h31, 6'h09, 6'h25,
		6'h18, 6'h11, 6'h31, 6'h27, 6'h10, 6'h01, 6'h08, 6'h31};
	int errors = 0, total_checks = 0, cyc = 0;
	always #2 clk = ~clk;
	assign cfg = {port_reset_drive_select, ext_reset_pin_select, debug_access_allow,
		boot_clock_speed, debug_port_select, check_bytes_enable, digital_clock_phase_delay};
	nvm_core #(.EE_WRITE_CYC(20)) uut (.clk(clk), .rst(rst), .ce(1'b1), .por(por),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_fetch(rd_fetch), .rd_check_region(rd_check_region), .rd_ack(rd_ack),
		.rd_data(rd_data), .rd_fault(rd_fault), .rd_corrected(rd_corrected),
		.rd_uncorrectable(rd_uncorrectable), .fl_rd_en(fl_rd_en), .fl_rd_addr(fl_rd_addr),
		.fl_rd_check_region(), .fl_rd_word(fl_rd_word), .fl_busy(fl_busy), .pg_req(pg_req),
		.pg_op(pg_op), .pg_ext(pg_ext), .pg_row(10'h005), .pg_level(pg_level),
		.pg_done(pg_done), .pg_allowed(pg_allowed), .ecc_irq(ecc_irq), .ee_busy(ee_busy),
		.port_reset_drive_select(port_reset_drive_select),
		.ext_reset_pin_select(ext_reset_pin_select), .debug_access_allow(debug_access_allow),
		.boot_clock_speed(boot_clock_speed), .debug_port_select(debug_port_select),
		.check_bytes_enable(check_bytes_enable),
		.digital_clock_phase_delay(digital_clock_phase_delay));
	nvm_flash_model fmod (.clk(clk), .fl_rd_en(fl_rd_en), .fl_rd_addr(fl_rd_addr),
		.flip(flip), .fl_rd_word(fl_rd_word));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	function automatic logic [63:0] pat(input logic [17:0] a);
		return {4{1'b0, a[17:3]}};
	endfunction
	task ck(input string n, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [15:0] a, input logic [31:0] wd);
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= wd;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(negedge clk);
	endtask
	task frd(input logic [17:0] a, input logic f, input logic c, input logic [71:0] fx);
		@(posedge clk);
		rd_req <= 1'b1;
		rd_addr <= a;
		rd_fetch <= f;
		rd_check_region <= c;
		flip <= fx;
		do @(posedge clk); while (rd_ack !== 1'b1);
		d = rd_data;
		fl = {rd_fault, rd_corrected, rd_uncorrectable};
		rd_req <= 1'b0;
	endtask
	task pg(input logic [5:0] t);
		@(posedge clk);
		pg_req <= 1'b1;
		pg_op <= t[5:4];
		pg_ext <= t[3];
		pg_level <= t[2:1];
		do @(posedge clk); while (pg_done !== 1'b1);
		ck("pg_allowed", 64'(t[0]), 64'(pg_allowed));
		pg_req <= 1'b0;
	endtask
	task final_report;
		$display("Checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			final_report;
		end
	end
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		@(negedge clk);
		ck("cfg", 64'(28'h0000130), 64'(cfg));
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 16'(4 * i), 32'h0);
			ck("latch", 64'(i == 2 ? 8'h40 : i == 3 ? 8'h0A : 8'h00), 64'(q[7:0]));
		end
		frd(18'h00128, 1'b0, 1'b0, 72'h0);
		ck("rd_data", pat(18'h00128), d);
		ck("flags", 64'(3'b000), 64'(fl));
		frd(18'h00130, 1'b0, 1'b0, 72'h20);
		ck("rd_data", pat(18'h00130), d);
		ck("flags", 64'(3'b010), 64'(fl));
		bus(1'b0, nvm_pkg::NVM_ECC_STATUS, 32'h0);
		ck("status", 64'(2'b01), 64'(q[1:0]));
		ck("ecc_irq", 64'(1'b0), 64'(ecc_irq));
		bus(1'b1, nvm_pkg::NVM_ECC_MASK, 32'h1);
		ck("ecc_irq", 64'(1'b1), 64'(ecc_irq));
		frd(18'h00138, 1'b0, 1'b0, 72'h3);
		ck("rd_data", pat(18'h00138) ^ 64'h3, d);
		ck("flags", 64'(3'b001), 64'(fl));
		bus(1'b1, nvm_pkg::NVM_ECC_STATUS, 32'h3);
		ck("ecc_irq", 64'(1'b0), 64'(ecc_irq));
		frd(18'h00140, 1'b1, 1'b1, 72'h0);
		ck("flags", 64'(3'b100), 64'(fl));
		@(posedge clk);
		fl_busy <= 1'b1;
		fork
			frd(18'h00148, 1'b1, 1'b0, 72'h0);
			begin
				repeat (6) begin
					@(negedge clk);
					ck("rd_ack", 64'(1'b0), 64'(rd_ack));
				end
				@(posedge clk);
				fl_busy <= 1'b0;
			end
		join
		ck("rd_data", pat(18'h00148), d);
		for (int i = 0; i < 16; i++) pg(pt[i]);
		bus(1'b0, 16'h0800, 32'h0);
		ck("unmapped", 64'h0, 64'(q));
		bus(1'b0, nvm_pkg::NVM_EE_WIN + 16'h1FFC, 32'h0);
		ck("ee_byte", 64'h0, 64'(q[7:0]));
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, nvm_pkg::NVM_EE_BUF + 16'(4 * k), 32'h13121110 + 32'h04040404 * k);
		end
		bus(1'b1, nvm_pkg::NVM_EE_ROW, 32'h3);
		bus(1'b1, nvm_pkg::NVM_EE_CMD, 32'(nvm_pkg::NVM_EE_CMD_PROGRAM));
		ck("ee_busy", 64'(1'b1), 64'(ee_busy));
		frd(18'h00150, 1'b0, 1'b0, 72'h0);
		ck("rd_data", pat(18'h00150), d);
		do bus(1'b0, nvm_pkg::NVM_EE_CMD, 32'h0); while (q[0] !== 1'b0);
		bus(1'b1, nvm_pkg::NVM_EE_WIN + 16'h00C0, 32'hFF);
		for (int j = 47; j < 65; j++) begin
			bus(1'b0, nvm_pkg::NVM_EE_WIN + 16'(4 * j), 32'h0);
			ck("ee_byte", 64'((j >= 48 && j < 64) ? 8'(j - 32) : 8'h00), 64'(q[7:0]));
		end
		bus(1'b1, nvm_pkg::NVM_EE_CMD, 32'(nvm_pkg::NVM_EE_CMD_ERASE));
		do bus(1'b0, nvm_pkg::NVM_EE_CMD, 32'h0); while (q[0] !== 1'b0);
		bus(1'b0, nvm_pkg::NVM_EE_WIN + 16'h00C8, 32'h0);
		ck("ee_byte", 64'h0, 64'(q[7:0]));
		bus(1'b1, 16'h0000, 32'hE4);
		bus(1'b1, 16'h0004, 32'h6C);
		bus(1'b1, 16'h0008, 32'h83);
		bus(1'b1, 16'h000C, 32'h55);
		ck("cfg", 64'(28'h0000130), 64'(cfg));
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		ck("cfg", 64'(28'hDB392C5), 64'(cfg));
		frd(18'h00158, 1'b0, 1'b0, 72'h20);
		ck("rd_data", pat(18'h00158) ^ 64'h20, d);
		ck("flags", 64'(3'b000), 64'(fl));
		pg(6'h08);
		final_report;
	end
endmodule
